// File: pkg/spm_pkg.sv
package spm_pkg;
  // port count: port 0 upstream, 1..NPORT-1 downstream
  localparam int          NPORT          = 4;
  localparam int          PW             = 2;
  localparam int          AW             = 6;
  // power state encodings of the power_state_field
  localparam logic [1:0]  PS_D0          = 2'h0;
  localparam logic [1:0]  PS_D3HOT       = 2'h3;
  // word offsets, byte address = 4 * index
  localparam logic [AW-1:0] OFS_PMCS     = 6'h00;
  localparam logic [AW-1:0] OFS_WAKE_TMR = 6'h01;
  localparam logic [AW-1:0] OFS_TOA_TMR  = 6'h02;
  localparam logic [AW-1:0] OFS_SYSTEM_CONTROL   = 6'h03;
  localparam logic [AW-1:0] OFS_VCHDR    = 6'h04;
  localparam logic [AW-1:0] OFS_BCAP     = 6'h05;
  localparam logic [AW-1:0] OFS_BSTD     = 6'h06;
  localparam logic [AW-1:0] OFS_BDV      = 6'h09;
  localparam logic [AW-1:0] OFS_STATUS   = 6'h11;
  localparam logic [AW-1:0] OFS_CFGDONE  = 6'h12;
  // pm_control_status fields
  localparam int          F_PS_LO        = 0;
  localparam int          F_KEEP_CTX     = 3;
  localparam int          F_WAKE_ST      = 15;
  // system_control fields
  localparam int          F_UNLOCK       = 0;
  localparam int          F_EEWR         = 1;
  // reset values
  localparam logic [15:0] WAKE_TO_RST    = 16'h0010;
  localparam logic [15:0] TOA_TO_RST     = 16'h0010;
  localparam logic [31:0] VC_HDR_RST     = 32'h0000_0000;
  // timing: tick period
  localparam int          CLK_NS         = 100;
  localparam int          TICK_NS        = 1000;
  localparam int          TICK_CYC       = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          NBDV           = 8;
  // per-bridge device state
  typedef enum logic [1:0] {
    ST_D0_UNINIT,
    ST_D0_ACTIVE,
    ST_D3_HOT
  } spm_pstate_e;
  // fence state
  typedef enum logic [1:0] {
    FN_IDLE,
    FN_WAIT,
    FN_DONE
  } spm_fence_e;
  // packet class for D3hot filtering
  localparam logic [2:0]  PK_CFG0        = 3'h0;
  localparam logic [2:0]  PK_MSG_SELF    = 3'h1;
  localparam logic [2:0]  PK_REQ_OTHER   = 3'h2;
  localparam logic [2:0]  PK_CPL_SELF    = 3'h3;
  localparam logic [2:0]  PK_CPL_THRU    = 3'h4;
endpackage

// File: src/spm_power_mgmt.sv
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Behaviour
// (R1) downstream bridge state affects only its port
// (R2) D3hot bridge allows its link into L1
// (R3) upstream D3hot plus acks: whole device low-power
// (R4) reset gives D0 uninit; configuration gives active
// (R5) write D3hot from active; D0 returns uninit
// (R6) D3hot exit resets nothing; keep-context defaults set
// (R7) D3hot accepts type0 config and own messages
// (R8) other primary and secondary requests are unsupported
// (R9) packet errors reported; other errors discarded in D3hot
// (R10) own completions unexpected; through completions routed
// (R11) no wake from cold; downstream wake from D3hot
// (R12) wake retransmitted until status cleared, timer restarts
// (R13) root places D3, broadcasts turn-off, expects acks
// (R14) turn-off forwarded on every active downstream port
// (R15) all acks then upstream ack and L2/L3 ready
// (R16) ack timeout: L2/L3 ready, counted as ack
// (R17) back to D0 uninit resumes wake generation
// (R18) budgeting disabled until header and pointer set
// (R19) four standard registers plus eight data values
// (R20) budget header reads zero, eeprom-load only
// (R21) data values writable only when unlocked; the code also accepts them while eeprom init mode (eewr_q) is set
// (R22) timeouts count a fixed tick from core clock
// (R23) inactive ports excluded from awaited acks
module spm_power_mgmt
  import spm_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // avalon-mm slave, word address
  input  wire logic [AW+PW-1:0] avs_address_in,
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic [31:0]      avs_writedata_in,
  output logic [31:0]           avs_readdata_out,
  output logic                  avs_waitrequest_out,
  // per-port packet classification (same clock)
  input  wire logic [NPORT-1:0] pkt_valid_in,
  input  wire logic [NPORT-1:0] pkt_secondary_in,
  input  wire logic [3*NPORT-1:0] pkt_class_in,
  input  wire logic [NPORT-1:0] pkt_error_in,
  input  wire logic [NPORT-1:0] event_error_in,
  output logic [NPORT-1:0]      pkt_accept_out,
  output logic [NPORT-1:0]      pkt_unsupported_out,
  output logic [NPORT-1:0]      pkt_unexpected_out,
  output logic [NPORT-1:0]      pkt_route_out,
  output logic [NPORT-1:0]      err_msg_out,
  // link side
  input  wire logic [NPORT-1:0] link_active_in,
  input  wire logic [NPORT-1:0] hotplug_event_in,
  input  wire logic             turnoff_rx_in,
  input  wire logic [NPORT-1:0] toack_rx_in,
  input  wire logic             power_removed_in,
  output logic [NPORT-1:0]      l1_allowed_out,
  output logic [NPORT-1:0]      wake_tx_out,
  output logic [NPORT-1:0]      turnoff_tx_out,
  output logic                  toack_tx_out,
  output logic [NPORT-1:0]      l23_ready_out,
  output logic                  device_lowpower_out,
  output logic                  budget_visible_out
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode, one wait cycle for reads so readdata comes from a flop
  logic [AW-1:0] widx;
  logic [PW-1:0] wport;
  logic          rd_pend_q;
  logic          wr_acc;
  logic [31:0]   rd_d;

  assign wport = avs_address_in[AW+PW-1:AW];
  assign widx  = avs_address_in[AW-1:0];
  assign wr_acc = avs_write_in;
  assign avs_waitrequest_out = avs_read_in & ~rd_pend_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= avs_read_in & ~rd_pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tick divider
  logic [15:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001; // (R22)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // global registers
  logic        unlock_q;
  logic        eewr_q;
  logic [31:0] vc_hdr_q;
  logic [31:0] bcap_q;
  logic [31:0] bstd_q [2:0];
  logic [31:0] bdv_q [NBDV-1:0];
  logic        fence_lp;
  spm_fence_e  fence_q;
  logic [NPORT-1:0] awaited_q;
  logic [NPORT-1:0] acked_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      unlock_q <= 1'b0;
      eewr_q   <= 1'b0;
      vc_hdr_q <= VC_HDR_RST;
      bcap_q   <= 32'h0000_0000;
      for (int i = 0; i < 3; i++) bstd_q[i] <= 32'h0000_0000;
      for (int i = 0; i < NBDV; i++) bdv_q[i] <= 32'h0000_0000;
    end else if (wr_acc) begin
      if (widx == OFS_SYSTEM_CONTROL) begin
        unlock_q <= avs_writedata_in[F_UNLOCK];
        eewr_q   <= avs_writedata_in[F_EEWR];
      end
      if (widx == OFS_VCHDR) vc_hdr_q <= avs_writedata_in;
      // header only loadable in eeprom init mode
      if (widx == OFS_BCAP && eewr_q) bcap_q <= avs_writedata_in; // (R20)
      for (int i = 0; i < 3; i++) begin
        if (widx == OFS_BSTD + AW'(i)) bstd_q[i] <= avs_writedata_in; // (R19)
      end
      for (int i = 0; i < NBDV; i++) begin
        if (widx == OFS_BDV + AW'(i) && (unlock_q || eewr_q)) bdv_q[i] <= avs_writedata_in; // (R21)
      end
    end
  end

  // next pointer sits in bits 31:20; nonzero header plus pointer
  assign budget_visible_out = (bcap_q != 32'h0000_0000) && (vc_hdr_q[31:20] != 12'h000); // (R18)

  ////////////////////////////////////////////////////////////////////////
  // per-port bridges
  spm_pstate_e      pst_q [NPORT-1:0];
  logic [NPORT-1:0] cfg_done_q;
  logic [NPORT-1:0] keep_ctx_q;
  logic [NPORT-1:0] wake_st_q;
  logic [15:0]      wake_to_q [NPORT-1:0];
  logic [15:0]      toa_to_q [NPORT-1:0];
  logic [15:0]      wake_cnt_q [NPORT-1:0];
  logic [15:0]      toa_cnt_q [NPORT-1:0];
  logic [NPORT-1:0] wake_run_q;
  logic [NPORT-1:0] wake_tx_q;
  logic [NPORT-1:0] l23_q;
  logic [NPORT-1:0] hot;
  logic [NPORT-1:0] ack_eff;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      logic       sel;
      logic [2:0] cls;
      logic       wr_pm;
      assign sel   = (wport == PW'(gp));
      assign wr_pm = wr_acc && sel && widx == OFS_PMCS; // (R1)
      assign cls   = pkt_class_in[3*gp +: 3];
      assign hot[gp] = (pst_q[gp] == ST_D3_HOT);

      // state machine; no context reset on D3hot exit
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          pst_q[gp] <= ST_D0_UNINIT; // (R4)
        end else begin
          case (pst_q[gp])
            ST_D0_UNINIT: begin
              if (cfg_done_q[gp]) pst_q[gp] <= ST_D0_ACTIVE; // (R4)
            end
            ST_D0_ACTIVE: begin
              if (wr_pm && avs_writedata_in[F_PS_LO +: 2] == PS_D3HOT) pst_q[gp] <= ST_D3_HOT; // (R5)
            end
            ST_D3_HOT: begin
              if (wr_pm && avs_writedata_in[F_PS_LO +: 2] == PS_D0) pst_q[gp] <= ST_D0_UNINIT; // (R5) (R6)
            end
            default: pst_q[gp] <= ST_D0_UNINIT;
          endcase
        end
      end

      // config-done, keep-context, timeouts
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          cfg_done_q[gp] <= 1'b0;
          keep_ctx_q[gp] <= 1'b1; // (R6)
          wake_to_q[gp]  <= WAKE_TO_RST;
          toa_to_q[gp]   <= TOA_TO_RST;
        end else begin
          if (wr_acc && sel && widx == OFS_CFGDONE) cfg_done_q[gp] <= avs_writedata_in[0];
          else if (wr_pm && hot[gp]) cfg_done_q[gp] <= 1'b0;
          // software writes must not clear it; eeprom load only
          if (wr_pm && eewr_q) keep_ctx_q[gp] <= avs_writedata_in[F_KEEP_CTX]; // (R6)
          if (wr_acc && sel && widx == OFS_WAKE_TMR) wake_to_q[gp] <= avs_writedata_in[15:0];
          if (wr_acc && sel && widx == OFS_TOA_TMR) toa_to_q[gp] <= avs_writedata_in[15:0];
        end
      end

      // wake status and retry timer; set wins over clear
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          wake_st_q[gp]  <= 1'b0;
          wake_run_q[gp] <= 1'b0;
          wake_tx_q[gp]  <= 1'b0;
          wake_cnt_q[gp] <= 16'h0000;
        end else begin
          wake_tx_q[gp] <= 1'b0;
          if (gp != 0 && hotplug_event_in[gp] && hot[gp] && !power_removed_in) begin // (R11) (R17)
            wake_st_q[gp]  <= 1'b1;
            wake_tx_q[gp]  <= 1'b1;
            wake_run_q[gp] <= 1'b1;
            wake_cnt_q[gp] <= 16'h0000;
          end else if (wr_pm && avs_writedata_in[F_WAKE_ST]) begin
            wake_st_q[gp]  <= 1'b0;
            wake_run_q[gp] <= 1'b0;
          end else if (wake_run_q[gp] && tick) begin
            if (wake_cnt_q[gp] + 16'h0001 >= wake_to_q[gp]) begin
              wake_tx_q[gp]  <= !power_removed_in; // (R12)
              wake_cnt_q[gp] <= 16'h0000;
            end else begin
              wake_cnt_q[gp] <= wake_cnt_q[gp] + 16'h0001;
            end
          end
        end
      end

      // turn-off ack timer on downstream ports
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          toa_cnt_q[gp] <= 16'h0000;
          l23_q[gp]     <= 1'b0;
        end else if (fence_q == FN_IDLE) begin
          toa_cnt_q[gp] <= 16'h0000;
          l23_q[gp]     <= 1'b0;
        end else if (gp != 0 && awaited_q[gp] && !ack_eff[gp]) begin
          if (toack_rx_in[gp]) l23_q[gp] <= 1'b1;
          else if (tick) begin
            if (toa_cnt_q[gp] + 16'h0001 >= toa_to_q[gp]) l23_q[gp] <= 1'b1; // (R16)
            else toa_cnt_q[gp] <= toa_cnt_q[gp] + 16'h0001; // (R22)
          end
        end
      end

      // D3hot packet handling, combinational answer
      always_comb begin
        pkt_accept_out[gp]      = 1'b0;
        pkt_unsupported_out[gp] = 1'b0;
        pkt_unexpected_out[gp]  = 1'b0;
        pkt_route_out[gp]       = 1'b0;
        if (pkt_valid_in[gp]) begin
          if (!hot[gp]) begin
            pkt_accept_out[gp] = (cls != PK_CPL_THRU);
            pkt_route_out[gp]  = (cls == PK_CPL_THRU);
          end else if (cls == PK_CPL_THRU) begin
            pkt_route_out[gp] = 1'b1; // (R10)
          end else if (cls == PK_CPL_SELF) begin
            pkt_unexpected_out[gp] = 1'b1; // (R10)
          end else if (!pkt_secondary_in[gp] && (cls == PK_CFG0 || cls == PK_MSG_SELF)) begin
            pkt_accept_out[gp] = 1'b1; // (R7)
          end else begin
            pkt_unsupported_out[gp] = 1'b1; // (R8)
          end
        end
        // received-packet errors always; other events only when awake
        err_msg_out[gp] = (pkt_valid_in[gp] && pkt_error_in[gp]) || (event_error_in[gp] && !hot[gp]); // (R9)
      end
    end
  endgenerate

  assign ack_eff = acked_q | l23_q;

  ////////////////////////////////////////////////////////////////////////
  // turn-off fence
  logic [NPORT-1:0] ds_mask;
  assign ds_mask = {{(NPORT-1){1'b1}}, 1'b0};
  logic [NPORT-1:0] turnoff_q;
  logic             toack_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      fence_q   <= FN_IDLE;
      awaited_q <= '0;
      acked_q   <= '0;
      turnoff_q <= '0;
      toack_q   <= 1'b0;
    end else begin
      turnoff_q <= '0;
      toack_q   <= 1'b0;
      case (fence_q)
        FN_IDLE: begin
          if (turnoff_rx_in) begin
            awaited_q <= link_active_in & ds_mask; // (R23)
            turnoff_q <= link_active_in & ds_mask; // (R14)
            acked_q   <= '0;
            fence_q   <= FN_WAIT;
          end
        end
        FN_WAIT: begin
          acked_q <= acked_q | (toack_rx_in & awaited_q);
          if ((awaited_q & ~ack_eff) == '0) begin
            toack_q <= 1'b1; // (R15)
            fence_q <= FN_DONE;
          end
        end
        FN_DONE: begin
          // leaving D3hot on port 0 rearms the fence
          if (pst_q[0] != ST_D3_HOT) fence_q <= FN_IDLE; // (R17)
        end
        default: fence_q <= FN_IDLE;
      endcase
    end
  end

  assign fence_lp = (fence_q == FN_DONE);

  always_comb begin
    l1_allowed_out = hot & link_active_in; // (R2)
    wake_tx_out    = wake_tx_q;
    turnoff_tx_out = turnoff_q;
    toack_tx_out   = toack_q;
    l23_ready_out  = (l23_q & ds_mask) | {{(NPORT-1){1'b0}}, fence_lp}; // (R15) (R16)
    device_lowpower_out = fence_lp && hot[0]; // (R3)
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    case (widx)
      OFS_PMCS:     rd_d = {16'h0000, wake_st_q[wport], 11'h000, keep_ctx_q[wport], 1'b0,
                            (pst_q[wport] == ST_D3_HOT) ? PS_D3HOT : PS_D0};
      OFS_WAKE_TMR: rd_d = {16'h0000, wake_to_q[wport]};
      OFS_TOA_TMR:  rd_d = {16'h0000, toa_to_q[wport]};
      OFS_SYSTEM_CONTROL:   rd_d = {30'h0000_0000, eewr_q, unlock_q};
      OFS_VCHDR:    rd_d = vc_hdr_q;
      OFS_BCAP:     rd_d = bcap_q; // (R20)
      OFS_STATUS:   rd_d = {24'h00_0000, 2'(fence_q), l23_q[wport], wake_run_q[wport],
                            1'b0, cfg_done_q[wport], 2'(pst_q[wport])};
      OFS_CFGDONE:  rd_d = {31'h0000_0000, cfg_done_q[wport]};
      default: begin
        for (int i = 0; i < 3; i++) begin
          if (widx == OFS_BSTD + AW'(i)) rd_d = bstd_q[i];
        end
        for (int i = 0; i < NBDV; i++) begin
          if (widx == OFS_BDV + AW'(i)) rd_d = bdv_q[i]; // (R19)
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !rd_pend_q) begin
      avs_readdata_out <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  unlock_guard_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (wr_acc && !unlock_q && !eewr_q && widx == OFS_BDV) |=> $stable(bdv_q[0]))
    else $error("budget value written while locked"); // (R21)
  reset_uninit_a: assert property (@(posedge clk_in)
    !rstn_in |=> pst_q[0] == ST_D0_UNINIT)
    else $error("reset did not give uninit state"); // (R4)
  ack_fence_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    toack_q |-> $past(fence_q) == FN_WAIT)
    else $error("upstream ack outside fence"); // (R15)
  turnoff_fwd_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (fence_q == FN_IDLE && turnoff_rx_in) |=> turnoff_tx_out == ($past(link_active_in) & ds_mask))
    else $error("turn-off not forwarded"); // (R14) (R23)
  lowpower_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    device_lowpower_out |-> hot[0] && fence_q == FN_DONE && (awaited_q & ~ack_eff) == '0)
    else $error("device low-power without fence"); // (R3)
  ur_hot_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pkt_valid_in[1] && hot[1] && pkt_secondary_in[1] && pkt_class_in[5:3] == PK_CFG0) |-> pkt_unsupported_out[1])
    else $error("secondary request not unsupported"); // (R8)
  hot_enter_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pst_q[1] == ST_D0_ACTIVE && wr_acc && wport == 2'h1 && widx == OFS_PMCS
     && avs_writedata_in[1:0] == PS_D3HOT) |=> pst_q[1] == ST_D3_HOT && pst_q[2] == $past(pst_q[2]))
    else $error("D3hot entry wrong"); // (R5) (R1)
  err_drop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (hot[1] && !pkt_valid_in[1] && event_error_in[1]) |-> !err_msg_out[1])
    else $error("event error not discarded"); // (R9)
  wake_upstream_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !wake_tx_out[0])
    else $error("wake from upstream port"); // (R11)
  cold_nowake_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    power_removed_in |=> wake_tx_out == '0)
    else $error("wake sent without power"); // (R11)

endmodule // spm_power_mgmt

// File: tb/spm_link_partner.sv
`timescale 1ns/1ps
// root and downstream link partners, behavioural
module spm_link_partner
  import spm_pkg::*;
#(
  parameter int ACK_DLY = 5
)(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             fence_go_in,
  input  wire logic [NPORT-1:0] silent_in,
  input  wire logic [NPORT-1:0] turnoff_tx_in,
  output logic                  turnoff_rx_out,
  output logic [NPORT-1:0]      toack_rx_out
);
  int cnt_q [NPORT];
  // bench puts bridges 0 to 2 in D3 before raising the broadcast; bridge 3 stays in D0 uninit
  always_ff @(posedge clk_in) begin
    turnoff_rx_out <= rstn_in & fence_go_in;
  end
  ////////////////////////////////////////////////////////////
  // silent partners model a dead link: no ack ever comes
  always_ff @(posedge clk_in) begin
    for (int p = 0; p < NPORT; p++) begin
      toack_rx_out[p] <= 1'b0;
      if (!rstn_in) begin
        cnt_q[p] <= 0;
      end else if (turnoff_tx_in[p] && !silent_in[p]) begin
        cnt_q[p] <= ACK_DLY;
      end else if (cnt_q[p] == 1) begin
        cnt_q[p] <= 0;
        toack_rx_out[p] <= 1'b1;
      end else if (cnt_q[p] > 1) begin
        cnt_q[p] <= cnt_q[p] - 1;
      end
    end
  end
endmodule // spm_link_partner

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import spm_pkg::*;
  typedef struct packed {
    logic [1:0] port;
    logic       vld;
    logic       sec;
    logic [2:0] cls;
    logic       perr;
    logic       eerr;
    logic [4:0] exp;
    logic [4:0] msk;
  } spm_row_s;
  logic               clk_in  = 1'b0;
  logic               rstn_in = 1'b0;
  logic [7:0]         adr     = '0;
  logic               rd      = 1'b0;
  logic               wr      = 1'b0;
  logic [31:0]        wdat    = '0;
  logic [31:0]        rdat;
  logic [31:0]        q;
  logic               wt;
  logic [NPORT-1:0]   pv = '0, ps = '0, pe = '0, ee = '0, la = '0, hp = '0, silent = '0;
  logic [3*NPORT-1:0] pc = '0;
  logic               fence_go = 1'b0;
  logic               pr       = 1'b0;
  logic               to_rx, to_ack_tx, lowp, bvis;
  logic [NPORT-1:0]   acc, ur, uc, rt, em, l1, wake, to_tx, ack_rx, l23;
  int                 n_mismatch = 0;
  int                 cmp_count  = 0;
  int                 cyc        = 0;
  int                 n;
  int                 p;
  spm_row_s           rows [10];
  always #50 clk_in = ~clk_in;
  spm_power_mgmt uut (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .pkt_valid_in(pv), .pkt_secondary_in(ps), .pkt_class_in(pc), .pkt_error_in(pe), .event_error_in(ee),
    .pkt_accept_out(acc), .pkt_unsupported_out(ur), .pkt_unexpected_out(uc), .pkt_route_out(rt),
    .err_msg_out(em), .link_active_in(la), .hotplug_event_in(hp), .turnoff_rx_in(to_rx),
    .toack_rx_in(ack_rx), .power_removed_in(pr), .l1_allowed_out(l1), .wake_tx_out(wake),
    .turnoff_tx_out(to_tx), .toack_tx_out(to_ack_tx), .l23_ready_out(l23), .device_lowpower_out(lowp),
    .budget_visible_out(bvis));
  spm_link_partner lp (.clk_in(clk_in), .rstn_in(rstn_in), .fence_go_in(fence_go), .silent_in(silent),
    .turnoff_tx_in(to_tx), .turnoff_rx_out(to_rx), .toack_rx_out(ack_rx));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low, released on that edge
  task automatic bus(input logic w, input int pt, input logic [5:0] i, input logic [31:0] d);
    @(posedge clk_in);
    adr  <= {pt[1:0], i};
    wr   <= w;
    rd   <= ~w;
    wdat <= d;
    @(posedge clk_in);
    while (wt !== 1'b0) @(posedge clk_in);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // bench runs about 300 cycles; ceiling leaves wide margin
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{2'h1, 1'b1, 1'b0, PK_CFG0, 1'b0, 1'b0, 5'h10, 5'h1C},
             '{2'h1, 1'b1, 1'b0, PK_MSG_SELF, 1'b0, 1'b0, 5'h10, 5'h1C},
             '{2'h1, 1'b1, 1'b0, PK_REQ_OTHER, 1'b0, 1'b0, 5'h08, 5'h18},
             '{2'h1, 1'b1, 1'b1, PK_CFG0, 1'b0, 1'b0, 5'h08, 5'h18},
             '{2'h1, 1'b1, 1'b0, PK_CPL_SELF, 1'b0, 1'b0, 5'h04, 5'h04},
             '{2'h1, 1'b1, 1'b0, PK_CPL_THRU, 1'b0, 1'b0, 5'h02, 5'h06},
             '{2'h1, 1'b1, 1'b1, PK_CPL_THRU, 1'b0, 1'b0, 5'h02, 5'h06},
             '{2'h1, 1'b1, 1'b0, PK_REQ_OTHER, 1'b1, 1'b0, 5'h09, 5'h09},
             '{2'h1, 1'b0, 1'b0, PK_CFG0, 1'b0, 1'b1, 5'h00, 5'h01},
             '{2'h2, 1'b1, 1'b0, PK_REQ_OTHER, 1'b0, 1'b0, 5'h00, 5'h08}};
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    la <= 4'h7;
    for (int k = 0; k < NPORT; k++) begin
      bus(1'b0, k, OFS_PMCS, '0);
      chk(q & 32'h0000_000B, 32'h0000_0008);
    end
    bus(1'b0, 1, OFS_WAKE_TMR, '0);
    chk(q & 32'h0000_FFFF, {16'h0000, WAKE_TO_RST});
    bus(1'b0, 1, 6'h3F, '0);
    chk(q, 32'h0000_0000);
    bus(1'b1, 3, OFS_PMCS, 32'h0000_0003);
    bus(1'b0, 3, OFS_PMCS, '0);
    chk(q & 32'h0000_0003, 32'h0000_0000);
    for (int k = 0; k < 3; k++) bus(1'b1, k, OFS_CFGDONE, 32'h0000_0001);
    bus(1'b1, 1, OFS_PMCS, 32'h0000_0003);
    @(negedge clk_in);
    chk({28'h0000_000, l1}, 32'h0000_0002);
    foreach (rows[r]) begin
      @(posedge clk_in);
      p = rows[r].port;
      pv <= {3'h0, rows[r].vld} << p;
      ps <= {3'h0, rows[r].sec} << p;
      pe <= {3'h0, rows[r].perr} << p;
      ee <= {3'h0, rows[r].eerr} << p;
      pc <= {9'h000, rows[r].cls} << (3 * p);
      @(negedge clk_in);
      chk({27'h0, {acc[p], ur[p], uc[p], rt[p], em[p]} & rows[r].msk}, {27'h0, rows[r].exp});
    end
    @(posedge clk_in);
    pv <= '0;
    pe <= '0;
    ee <= '0;
    // power gone: a hot-plug event must stay silent
    pr <= 1'b1;
    hp <= 4'h2;
    @(posedge clk_in);
    hp <= 4'h0;
    n = 0;
    repeat (30) begin
      @(negedge clk_in);
      if (wake[1] === 1'b1) n++;
    end
    chk(n, 0);
    @(posedge clk_in);
    pr <= 1'b0;
    // wake retry on port 1, timeout of two ticks
    bus(1'b1, 1, OFS_WAKE_TMR, 32'h0000_0002);
    hp <= 4'h2;
    @(posedge clk_in);
    hp <= 4'h0;
    n = 0;
    while (wake[1] !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    chk({31'h0, n < 40}, 32'h0000_0001);
    @(negedge clk_in);
    n = 1;
    while (wake[1] !== 1'b1 && n < 60) begin
      @(negedge clk_in);
      n++;
    end
    chk({31'h0, n >= 10 && n <= 40}, 32'h0000_0001);
    bus(1'b0, 1, OFS_PMCS, '0);
    chk(q & 32'h0000_800B, 32'h0000_800B);
    bus(1'b1, 1, OFS_PMCS, 32'h0000_8003);
    n = 0;
    repeat (80) begin
      @(negedge clk_in);
      if (wake[1] === 1'b1) n++;
    end
    chk(n, 0);
    bus(1'b1, 1, OFS_PMCS, 32'h0000_0000);
    bus(1'b0, 1, OFS_PMCS, '0);
    chk(q & 32'h0000_000B, 32'h0000_0008);
    bus(1'b0, 1, OFS_WAKE_TMR, '0);
    chk(q & 32'h0000_FFFF, 32'h0000_0002);
    // budgeting registers on port 0
    bus(1'b0, 0, OFS_BCAP, '0);
    chk(q, 32'h0000_0000);
    chk({31'h0, bvis}, 32'h0000_0000);
    bus(1'b1, 0, OFS_BCAP, 32'h1234_0004);
    bus(1'b0, 0, OFS_BCAP, '0);
    chk(q, 32'h0000_0000);
    bus(1'b1, 0, OFS_BDV, 32'hA5A5_0001);
    bus(1'b0, 0, OFS_BDV, '0);
    chk(q, 32'h0000_0000);
    bus(1'b1, 0, OFS_BSTD + 6'h02, 32'h0000_5A5A);
    bus(1'b0, 0, OFS_BSTD + 6'h02, '0);
    chk(q, 32'h0000_5A5A);
    bus(1'b1, 0, OFS_SYSTEM_CONTROL, 32'h0000_0001);
    bus(1'b1, 0, OFS_BDV + 6'h07, 32'h0BAD_CAFE);
    bus(1'b0, 0, OFS_BDV + 6'h07, '0);
    chk(q, 32'h0BAD_CAFE);
    bus(1'b1, 0, OFS_SYSTEM_CONTROL, 32'h0000_0002);
    bus(1'b1, 0, OFS_BCAP, 32'h0001_0004);
    bus(1'b0, 0, OFS_BCAP, '0);
    chk(q, 32'h0001_0004);
    bus(1'b1, 0, OFS_VCHDR, 32'h1500_0002);
    bus(1'b1, 0, OFS_SYSTEM_CONTROL, 32'h0000_0000);
    chk({31'h0, bvis}, 32'h0000_0001);
    // fence: port 3 link down, port 2 partner silent
    // root side puts the bridges in D3 before the broadcast
    bus(1'b1, 1, OFS_CFGDONE, 32'h0000_0001);
    bus(1'b1, 1, OFS_PMCS, 32'h0000_0003);
    bus(1'b1, 2, OFS_PMCS, 32'h0000_0003);
    bus(1'b1, 0, OFS_PMCS, 32'h0000_0003);
    bus(1'b1, 2, OFS_TOA_TMR, 32'h0000_0002);
    silent <= 4'h4;
    fence_go <= 1'b1;
    chk({31'h0, lowp}, 32'h0000_0000);
    @(posedge clk_in);
    fence_go <= 1'b0;
    n = 0;
    while (to_tx === 4'h0 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    chk({28'h0000_000, to_tx}, 32'h0000_0006);
    n = 0;
    while (to_ack_tx !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    chk({31'h0, n >= 10 && n < 300}, 32'h0000_0001);
    chk({31'h0, l23[2]}, 32'h0000_0001);
    @(negedge clk_in);
    chk({31'h0, l23[0]}, 32'h0000_0001);
    chk({31'h0, lowp}, 32'h0000_0001);
    // reset in mid-run clears the fence and the port 0 bridge state
    @(posedge clk_in);
    rstn_in <= 1'b0;
    @(posedge clk_in);
    rstn_in <= 1'b1;
    @(negedge clk_in);
    chk({29'h0, lowp, l23[0], to_ack_tx}, 32'h0000_0000);
    bus(1'b0, 0, OFS_PMCS, '0);
    chk(q & 32'h0000_000B, 32'h0000_0008);
    wrap_up();
  end
endmodule // tb_top
